// >>> bce_estimator.sv
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module bce_estimator #(
  parameter int TICK_CYCLES = bce_pkg::TICK_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        potential_valid_i,
  input  wire logic [7:0]  measured_potential_i,
  input  wire logic        current_valid_i,
  input  wire logic [15:0] current_i,
  input  wire logic        avg_valid_i,
  input  wire logic [15:0] averaged_current_i,
  input  wire logic        charge_valid_i,
  input  wire logic [15:0] charge_delta_i,
  input  wire logic [14:0] full_ratio_i,
  input  wire logic [12:0] heavy_empty_ratio_i,
  input  wire logic [12:0] light_empty_ratio_i,
  input  wire logic [15:0] full_ref_at_fifty_deg_i,
  output logic      [15:0] coulomb_count_o,
  output logic             full_charge_flag_o,
  output logic             heavy_empty_flag_o,
  output logic             learn_cycle_flag_o
);

  typedef struct packed {
    bce_pkg::bce_state_t st;
    logic [2:0]          ridx;
    logic [6:0][15:0]    prm;
    logic [7:0]          saved_ws;
    logic [15:0]         coulomb_count;
    logic [21:0]         age;
    logic                measured_potential_ok;
    logic                avg_prev_ok;
    logic [1:0]          cur_q;
    logic                above_vae;
    logic                full_f;
    logic                hempty_f;
    logic                learn_f;
    logic [29:0]         tick;
    logic [14:0]         fr;
    logic [12:0]         her;
    logic [12:0]         ler;
    logic [15:0]         hmah;
    logic [15:0]         lmah;
    logic [7:0]          hpct;
    logic [7:0]          lpct;
    logic [15:0]         rdata;
    logic                nv_we;
    logic [2:0]          nv_waddr;
    logic [15:0]         nv_wdata;
  } bce_regs_t;

  bce_regs_t s;
  bce_regs_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile parameter store

  logic [15:0] nv_rdata;
  logic [2:0]  nv_raddr;

  assign nv_raddr = (s.ridx == 3'h7) ? 3'h0 : s.ridx;

  bce_nv_mem #(
    .WIDTH (bce_pkg::NV_WIDTH),
    .DEPTH (bce_pkg::NV_DEPTH)
  ) u_nv (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .we_i    (s.nv_we),
    .waddr_i (s.nv_waddr),
    .wdata_i (s.nv_wdata),
    .raddr_i (nv_raddr),
    .rdata_o (nv_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic on present state

  function automatic logic [15:0] f_mah(input logic [15:0] rem, input logic [7:0] cond);
    logic [23:0] q;
    q = ({8'h00, rem} * {16'h0000, cond}) / bce_pkg::MAH_DIV;
    return (q[23:16] != 8'h00) ? 16'hffff : q[15:0];
  endfunction

  function automatic logic [7:0] f_pct(input logic [15:0] rem, input logic [15:0] den);
    logic [22:0] num;
    logic [22:0] q;
    num = {7'h00, rem} * {16'h0000, bce_pkg::PCT_SCALE};
    q   = (den == 16'h0000) ? 23'h000000 : num / {7'h00, den};
    return (q > 23'h0000ff) ? 8'hff : q[7:0];
  endfunction

  logic [7:0]  cond;
  logic [7:0]  ws;
  logic [15:0] fref;
  logic [14:0] fr_c;
  logic [30:0] full_prod;
  logic [15:0] full_cap;
  logic [28:0] he_prod;
  logic [28:0] le_prod;
  logic [15:0] he_chg;
  logic [15:0] le_chg;
  logic [23:0] ws_prod;
  logic [15:0] ws_cap;
  logic [15:0] rem_h;
  logic [15:0] rem_l;
  logic [15:0] den_h;
  logic [15:0] den_l;
  logic [7:0]  hpct_new;
  logic [22:0] lws_q;
  logic [7:0]  lws;

  assign cond = s.prm[bce_pkg::P_COND][7:0];
  assign ws   = s.prm[bce_pkg::P_WS][7:0];
  assign fref = full_ref_at_fifty_deg_i;
  assign fr_c      = (full_ratio_i > bce_pkg::FULL_MAX) ? bce_pkg::FULL_MAX : full_ratio_i;
  assign full_prod = {16'h0000, fr_c} * {15'h0000, fref};
  assign full_cap  = full_prod[29:14];
  assign he_prod   = {16'h0000, heavy_empty_ratio_i} * {13'h0000, fref};
  assign le_prod   = {16'h0000, light_empty_ratio_i} * {13'h0000, fref};
  assign he_chg    = {1'b0, he_prod[28:14]};
  assign le_chg    = {1'b0, le_prod[28:14]};
  // wear scale applied as 2^-7 fraction
  assign ws_prod   = {16'h0000, ws} * {8'h00, full_cap};
  assign ws_cap    = ws_prod[23] ? 16'hffff : ws_prod[22:7];
  // remaining charge above the empty point
  assign rem_h     = (s.coulomb_count > he_chg) ? (s.coulomb_count - he_chg) : 16'h0000;
  assign rem_l     = (s.coulomb_count > le_chg) ? (s.coulomb_count - le_chg) : 16'h0000;
  assign den_h     = (ws_cap > he_chg) ? (ws_cap - he_chg) : 16'h0000;
  assign den_l     = (ws_cap > le_chg) ? (ws_cap - le_chg) : 16'h0000;
  assign hpct_new  = f_pct(rem_h, den_h);
  // learned wear scale: coulomb count over full capacity
  assign lws_q     = (full_cap == 16'h0000) ? {15'h0000, bce_pkg::WS_UNAGED}
                   : {s.coulomb_count, 7'h00} / {7'h00, full_cap};
  assign lws       = (lws_q > {15'h0000, bce_pkg::WS_UNAGED}) ? bce_pkg::WS_UNAGED
                   : (lws_q < {15'h0000, bce_pkg::WS_MIN}) ? bce_pkg::WS_MIN : lws_q[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic        wok;
    logic [2:0]  widx;
    logic [15:0] wval;
    logic [17:0] acc;
    logic [15:0] dmag;
    logic [21:0] age_n;
    logic        aok;
    logic        below;
    wok   = 1'b0;
    widx  = 3'h0;
    wval  = 16'h0000;
    acc   = 18'h00000;
    dmag  = 16'h0000;
    age_n = 22'h000000;
    aok   = 1'b0;
    below = 1'b0;
    next_s = s;
    next_s.nv_we = 1'b0;
    next_s.rdata = 16'h0000;

    case (s.st)
      bce_pkg::ST_RESTORE: begin
        // restore stored parameters, wear scale last
        if (s.ridx != 3'h0) begin
          next_s.prm[3'(s.ridx - 3'h1)] = nv_rdata;
        end
        if (s.ridx == 3'h7) begin
          next_s.saved_ws = nv_rdata[7:0];
          next_s.st = bce_pkg::ST_RUN;
        end
        next_s.ridx = 3'(s.ridx + 3'h1);
      end
      default: begin
        next_s.st = bce_pkg::ST_RUN;

        // coulomb count follows the accumulator deltas
        if (charge_valid_i) begin
          acc = {2'b00, s.coulomb_count} + {{2{charge_delta_i[15]}}, charge_delta_i};
          next_s.coulomb_count = acc[17] ? 16'h0000 : (acc[16] ? 16'hffff : acc[15:0]);
          if (charge_delta_i[15]) begin
            dmag = 16'(-charge_delta_i);
            age_n = s.age + {6'h00, dmag};
            // compare with 32 times wear charge
            if (age_n >= {1'b0, s.prm[bce_pkg::P_AC], 5'h00}) begin
              next_s.age = 22'h000000;
              if (ws > bce_pkg::WS_MIN) begin
                next_s.prm[bce_pkg::P_WS] = {8'h00, 8'(ws - 8'h01)};
              end
            end else begin
              next_s.age = age_n;
            end
          end
        end

        // heavy discharge qualifier on each current reading
        if (current_valid_i) begin
          aok = $signed(current_i) < -$signed({1'b0, s.prm[bce_pkg::P_IAE][7:0], 7'h00});
          next_s.cur_q = {s.cur_q[0], aok};
        end

        if (potential_valid_i) begin
          // window broken by any reading at or below charge end
          if (measured_potential_i <= s.prm[bce_pkg::P_CHARGE_END_POTENTIAL][7:0]) begin
            next_s.measured_potential_ok = 1'b0;
          end
          below = measured_potential_i < s.prm[bce_pkg::P_VAE][7:0];
          next_s.above_vae = !below;
          if (below) begin
            next_s.hempty_f = 1'b1;
            // falling edge after two heavy readings
            if (s.above_vae && (s.cur_q == 2'b11)) begin
              next_s.learn_f = 1'b1;
            end
            if (next_s.learn_f || (s.coulomb_count > he_chg)) begin
              next_s.coulomb_count = he_chg;
            end
          end
        end

        // positive, nonzero and below the charge-end current
        if (avg_valid_i) begin
          aok = ($signed(averaged_current_i) > 16'sh0000) &&
                ($signed(averaged_current_i) <
                 $signed({3'b000, s.prm[bce_pkg::P_CHARGE_END_CURRENT_THRESHOLD][7:0], 5'h00}));
          // two qualified averages with potential held high
          if (aok && s.avg_prev_ok && s.measured_potential_ok) begin
            next_s.full_f = 1'b1;
            if (s.learn_f) begin
              // relearn wear scale, then load on next cycle
              next_s.learn_f = 1'b0;
              next_s.prm[bce_pkg::P_WS] = {8'h00, lws};
              next_s.st = bce_pkg::ST_FULL_LOAD;
            end else begin
              next_s.coulomb_count = ws_cap;
            end
          end
          next_s.avg_prev_ok = aok;
          next_s.measured_potential_ok = 1'b1;
        end

        // load follows the wear scale update
        if (s.st == bce_pkg::ST_FULL_LOAD) begin
          next_s.coulomb_count = ws_cap;
        end

        if (s.tick == 30'(TICK_CYCLES - 1)) begin
          next_s.tick = 30'h00000000;
          next_s.fr   = fr_c;
          next_s.her  = heavy_empty_ratio_i;
          next_s.ler  = light_empty_ratio_i;
          next_s.hmah = f_mah(rem_h, cond);
          next_s.lmah = f_mah(rem_l, cond);
          next_s.hpct = hpct_new;
          next_s.lpct = f_pct(rem_l, den_l);
          // clear only when no set arrives this cycle
          if ((hpct_new < bce_pkg::FULL_CLEAR_PCT) && !(next_s.full_f && !s.full_f)) begin
            next_s.full_f = 1'b0;
          end
          if ((hpct_new > bce_pkg::EMPTY_CLEAR_PCT) && !(potential_valid_i && below)) begin
            next_s.hempty_f = 1'b0;
          end
          // periodic save of a changed wear scale
          if (s.saved_ws != ws) begin
            next_s.saved_ws = ws;
            next_s.nv_we    = 1'b1;
            next_s.nv_waddr = bce_pkg::P_WS;
            next_s.nv_wdata = {8'h00, ws};
          end
        end else begin
          next_s.tick = 30'(s.tick + 30'h00000001);
        end

        // host writes take the store port over a pending save
        if (wr_i) begin
          wok = 1'b1;
          if (addr_i == bce_pkg::A_COND) begin
            widx = bce_pkg::P_COND;
          end else if (addr_i == bce_pkg::A_CHARGE_END_POTENTIAL) begin
            widx = bce_pkg::P_CHARGE_END_POTENTIAL;
          end else if (addr_i == bce_pkg::A_CHARGE_END_CURRENT_THRESHOLD) begin
            widx = bce_pkg::P_CHARGE_END_CURRENT_THRESHOLD;
          end else if (addr_i == bce_pkg::A_VAE) begin
            widx = bce_pkg::P_VAE;
          end else if (addr_i == bce_pkg::A_IAE) begin
            widx = bce_pkg::P_IAE;
          end else if (addr_i == bce_pkg::A_AC) begin
            widx = bce_pkg::P_AC;
          end else if (addr_i == bce_pkg::A_WS) begin
            widx = bce_pkg::P_WS;
          end else begin
            wok = 1'b0;
          end
          // only the wear charge is two bytes wide
          wval = (widx == bce_pkg::P_AC) ? wdata_i : {8'h00, wdata_i[7:0]};
          if (wok) begin
            next_s.prm[widx] = wval;
            next_s.nv_we     = 1'b1;
            next_s.nv_waddr  = widx;
            next_s.nv_wdata  = wval;
            if (widx == bce_pkg::P_WS) begin
              next_s.saved_ws = wval[7:0];
            end
          end
        end
      end
    endcase

    // register reads, unmapped addresses answer zero
    if (rd_i) begin
      if (addr_i == bce_pkg::A_COND) begin
        next_s.rdata = s.prm[bce_pkg::P_COND];
      end else if (addr_i == bce_pkg::A_CHARGE_END_POTENTIAL) begin
        next_s.rdata = s.prm[bce_pkg::P_CHARGE_END_POTENTIAL];
      end else if (addr_i == bce_pkg::A_CHARGE_END_CURRENT_THRESHOLD) begin
        next_s.rdata = s.prm[bce_pkg::P_CHARGE_END_CURRENT_THRESHOLD];
      end else if (addr_i == bce_pkg::A_VAE) begin
        next_s.rdata = s.prm[bce_pkg::P_VAE];
      end else if (addr_i == bce_pkg::A_IAE) begin
        next_s.rdata = s.prm[bce_pkg::P_IAE];
      end else if (addr_i == bce_pkg::A_AC) begin
        next_s.rdata = s.prm[bce_pkg::P_AC];
      end else if (addr_i == bce_pkg::A_WS) begin
        next_s.rdata = s.prm[bce_pkg::P_WS];
      end else if (addr_i == bce_pkg::A_FULL) begin
        next_s.rdata = {1'b0, s.fr};
      end else if (addr_i == bce_pkg::A_HER) begin
        next_s.rdata = {3'b000, s.her};
      end else if (addr_i == bce_pkg::A_LER) begin
        next_s.rdata = {3'b000, s.ler};
      end else if (addr_i == bce_pkg::A_HMAH) begin
        next_s.rdata = s.hmah;
      end else if (addr_i == bce_pkg::A_LMAH) begin
        next_s.rdata = s.lmah;
      end else if (addr_i == bce_pkg::A_HPCT) begin
        next_s.rdata = {8'h00, s.hpct};
      end else if (addr_i == bce_pkg::A_LPCT) begin
        next_s.rdata = {8'h00, s.lpct};
      end else if (addr_i == bce_pkg::A_FLAGS) begin
        next_s.rdata[bce_pkg::FLAG_FULL]   = s.full_f;
        next_s.rdata[bce_pkg::FLAG_HEMPTY] = s.hempty_f;
        next_s.rdata[bce_pkg::FLAG_LEARN]  = s.learn_f;
      end else if (addr_i == bce_pkg::A_ACR) begin
        next_s.rdata = s.coulomb_count;
      end else begin
        next_s.rdata = 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.st <= bce_pkg::ST_RESTORE;
      for (int i = 0; i < bce_pkg::NV_DEPTH; i++) begin
        s.prm[i] <= bce_pkg::PRM_RESET;
      end
      s.saved_ws <= bce_pkg::WS_UNAGED;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o            = s.rdata;
  assign coulomb_count_o    = s.coulomb_count;
  assign full_charge_flag_o = s.full_f;
  assign heavy_empty_flag_o = s.hempty_f;
  assign learn_cycle_flag_o = s.learn_f;

endmodule // bce_estimator
`default_nettype wire

// >>> bce_estimator_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bce_estimator_checker #(
  parameter int TICK_CYCLES = 200
) (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        potential_valid_i,
  input wire logic [7:0]  measured_potential_i,
  input wire logic        avg_valid_i,
  input wire logic        charge_valid_i,
  input wire logic [12:0] heavy_empty_ratio_i,
  input wire logic [15:0] full_ref_at_fifty_deg_i,
  input wire logic [15:0] coulomb_count_o,
  input wire logic        full_charge_flag_o,
  input wire logic        heavy_empty_flag_o,
  input wire logic        learn_cycle_flag_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // shadow of the empty threshold, taken from host writes only
  logic [7:0]  vae_q;
  logic [28:0] prod_w;
  logic [15:0] empty_w;
  assign prod_w  = heavy_empty_ratio_i * full_ref_at_fifty_deg_i;
  assign empty_w = {1'b0, prod_w[28:14]};
  always_ff @(posedge mclk_i) begin
    if (wr_i && addr_i == bce_pkg::A_VAE)
      vae_q <= wdata_i[7:0];
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
  property p_wr_rd;
    wr_i && addr_i == bce_pkg::A_COND ##1 rd_i && addr_i == bce_pkg::A_COND
      |=> rdata_o == {8'h00, $past(wdata_i[7:0], 2)};
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("conductance readback wrong");
  property p_heavy_set;
    potential_valid_i && measured_potential_i < vae_q |=> heavy_empty_flag_o;
  endproperty
  a_heavy_set: assert property (p_heavy_set) else $error("empty flag not set");
  property p_lower;
    potential_valid_i && measured_potential_i < vae_q && !learn_cycle_flag_o && !charge_valid_i
      && coulomb_count_o > empty_w |=> coulomb_count_o == $past(empty_w);
  endproperty
  a_lower: assert property (p_lower) else $error("count not lowered to empty");
  property p_learn_clr;
    $fell(learn_cycle_flag_o) |-> full_charge_flag_o;
  endproperty
  a_learn_clr: assert property (p_learn_clr) else $error("learn cleared without full");
  property p_full_src;
    $rose(full_charge_flag_o) |-> $past(avg_valid_i);
  endproperty
  a_full_src: assert property (p_full_src) else $error("full without average update");
  property p_learn_src;
    $rose(learn_cycle_flag_o) |-> $past(potential_valid_i) && $past(measured_potential_i) < $past(vae_q)
      && heavy_empty_flag_o;
  endproperty
  a_learn_src: assert property (p_learn_src) else $error("learn without drop");
  property p_heavy_src;
    $rose(heavy_empty_flag_o) |-> $past(potential_valid_i);
  endproperty
  a_heavy_src: assert property (p_heavy_src) else $error("empty flag without reading");
  // a full load lands one cycle after the flag, so that cycle is exempt
  property p_count_still;
    !charge_valid_i && !potential_valid_i && !avg_valid_i && !$rose(full_charge_flag_o)
      |=> $stable(coulomb_count_o);
  endproperty
  a_count_still: assert property (p_count_still) else $error("count moved with no event");
  c_learn: cover property ($rose(learn_cycle_flag_o));
  c_full: cover property ($rose(full_charge_flag_o));
  c_heavy: cover property ($rose(heavy_empty_flag_o));
endmodule // bce_estimator_checker
bind bce_estimator bce_estimator_checker #(.TICK_CYCLES(TICK_CYCLES)) u_bce_estimator_checker (
  .mclk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .potential_valid_i,
  .measured_potential_i, .avg_valid_i, .charge_valid_i, .heavy_empty_ratio_i,
  .full_ref_at_fifty_deg_i, .coulomb_count_o, .full_charge_flag_o, .heavy_empty_flag_o,
  .learn_cycle_flag_o
);
`default_nettype wire

// >>> bce_nv_mem.sv
`timescale 1ns/100ps
`default_nettype none
// array has no reset on purpose: it stands in for nonvolatile storage
module bce_nv_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 7
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             we_i,
  input  wire logic [2:0]       waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [2:0]       raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule // bce_nv_mem
`default_nettype wire

// >>> bce_pkg.sv
package bce_pkg;

  // register byte addresses
  localparam logic [7:0] A_COND  = 8'h00;
  localparam logic [7:0] A_CHARGE_END_POTENTIAL  = 8'h04;
  localparam logic [7:0] A_CHARGE_END_CURRENT_THRESHOLD  = 8'h08;
  localparam logic [7:0] A_VAE   = 8'h0c;
  localparam logic [7:0] A_IAE   = 8'h10;
  localparam logic [7:0] A_AC    = 8'h14;
  localparam logic [7:0] A_WS    = 8'h18;
  localparam logic [7:0] A_FULL  = 8'h1c;
  localparam logic [7:0] A_HER   = 8'h20;
  localparam logic [7:0] A_LER   = 8'h24;
  localparam logic [7:0] A_HMAH  = 8'h28;
  localparam logic [7:0] A_LMAH  = 8'h2c;
  localparam logic [7:0] A_HPCT  = 8'h30;
  localparam logic [7:0] A_LPCT  = 8'h34;
  localparam logic [7:0] A_FLAGS = 8'h38;
  localparam logic [7:0] A_ACR   = 8'h3c;

  // flag register bit positions
  localparam int FLAG_FULL   = 0;
  localparam int FLAG_HEMPTY = 1;
  localparam int FLAG_LEARN  = 2;

  // parameter slots, same index in shadow and nonvolatile store
  localparam logic [2:0] P_COND = 3'h0;
  localparam logic [2:0] P_CHARGE_END_POTENTIAL = 3'h1;
  localparam logic [2:0] P_CHARGE_END_CURRENT_THRESHOLD = 3'h2;
  localparam logic [2:0] P_VAE  = 3'h3;
  localparam logic [2:0] P_IAE  = 3'h4;
  localparam logic [2:0] P_AC   = 3'h5;
  localparam logic [2:0] P_WS   = 3'h6;
  localparam int         NV_DEPTH  = 7;
  localparam int         NV_WIDTH  = 16;
  localparam logic [15:0] PRM_RESET = 16'h0000;

  // wear scale codes
  localparam logic [7:0] WS_UNAGED = 8'h80;
  localparam logic [7:0] WS_MIN    = 8'h3f;

  // fixed point and unit scaling
  localparam int          RATIO_FRAC = 14;
  localparam int          WS_FRAC    = 7;
  localparam int          AGE_SHIFT  = 5;
  localparam int          CHARGE_END_CURRENT_THRESHOLD_SHIFT = 5;
  localparam int          IAE_SHIFT  = 7;
  localparam logic [14:0] FULL_MAX   = 15'h4000;
  localparam logic [23:0] MAH_DIV    = 24'h0000a0;
  localparam logic [6:0]  PCT_SCALE  = 7'h64;
  localparam logic [7:0]  FULL_CLEAR_PCT  = 8'h5a;
  localparam logic [7:0]  EMPTY_CLEAR_PCT = 8'h05;

  // result interval
  localparam int TICK_TIME_MS  = 3500;
  localparam int CLK_FREQ_KHZ  = 200000;
  localparam int TICK_CYCLES   = TICK_TIME_MS * CLK_FREQ_KHZ;

  typedef enum logic [1:0] {
    ST_RESTORE   = 2'b00,
    ST_RUN       = 2'b01,
    ST_FULL_LOAD = 2'b10
  } bce_state_t;

endpackage

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [3:0]  vld = 4'h0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  measured_potential_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] current_i = 16'h0000;
  logic [15:0] averaged_current_i = 16'h0000;
  logic [15:0] charge_delta_i = 16'h0000;
  logic [14:0] full_ratio_i = 15'h5000;
  logic [12:0] heavy_empty_ratio_i = 13'h0000;
  logic [12:0] light_empty_ratio_i = 13'h1000;
  logic [15:0] full_ref_at_fifty_deg_i = 16'h1000;
  logic [15:0] rdata_o;
  logic [15:0] coulomb_count_o;
  logic        full_charge_flag_o;
  logic        heavy_empty_flag_o;
  logic        learn_cycle_flag_o;
  int          miscompares = 0;
  int          check_count = 0;
  wire  [2:0]  flg = {full_charge_flag_o, heavy_empty_flag_o, learn_cycle_flag_o};
  localparam logic [7:0]  PA [7] = '{bce_pkg::A_COND, bce_pkg::A_CHARGE_END_POTENTIAL, bce_pkg::A_CHARGE_END_CURRENT_THRESHOLD,
    bce_pkg::A_VAE, bce_pkg::A_IAE, bce_pkg::A_AC, bce_pkg::A_WS};
  localparam logic [15:0] PV [7] = '{16'h00a0, 16'h00c0, 16'h0004, 16'h0080, 16'h0002, 16'h0001, 16'h0080};
  localparam logic [7:0]  RA [7] = '{bce_pkg::A_FULL, bce_pkg::A_HER, bce_pkg::A_LER,
    bce_pkg::A_HMAH, bce_pkg::A_LMAH, bce_pkg::A_HPCT, bce_pkg::A_LPCT};
  localparam logic [15:0] RV [7] = '{16'h4000, 16'h0000, 16'h1000, 16'h0800, 16'h0400, 16'h0032, 16'h0021};

  bce_estimator #(.TICK_CYCLES(200)) u_bce_estimator (
    .mclk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .potential_valid_i(vld[0]), .measured_potential_i, .current_valid_i(vld[1]), .current_i,
    .avg_valid_i(vld[2]), .averaged_current_i, .charge_valid_i(vld[3]), .charge_delta_i,
    .full_ratio_i, .heavy_empty_ratio_i, .light_empty_ratio_i, .full_ref_at_fifty_deg_i,
    .coulomb_count_o, .full_charge_flag_o, .heavy_empty_flag_o, .learn_cycle_flag_o
  );

  always #2.5 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
    @(posedge mclk_i);
  endtask
  // k: 0 potential, 1 current, 2 average, 3 charge delta
  task automatic meas(input int k, input logic [15:0] v);
    vld[k] <= 1'b1;
    if (k == 0) measured_potential_i <= v[7:0];
    if (k == 1) current_i <= v;
    if (k == 2) averaged_current_i <= v;
    if (k == 3) charge_delta_i <= v;
    @(posedge mclk_i);
    vld <= 4'h0;
    @(posedge mclk_i);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // hang guard: the whole run needs about 550 cycles
  initial begin
    #100000;
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    chk({13'h0000, flg}, 16'h0000);
    rst_b_i <= 1'b1;
    repeat (9) @(posedge mclk_i);
    // junk in the upper byte must not stick in byte registers
    for (int i = 0; i < 7; i++) begin
      wr(PA[i], (i == 5) ? PV[i] : (PV[i] | 16'h5a00));
      rd(PA[i], PV[i]);
    end
    rd(8'hfc, 16'h0000);
    meas(3, 16'h0800);
    meas(3, 16'hffe0);
    wr(bce_pkg::A_ACR, 16'h1234);
    rd(bce_pkg::A_WS, 16'h007f);
    meas(3, 16'hffe1);
    rd(bce_pkg::A_WS, 16'h007f);
    rd(bce_pkg::A_ACR, 16'h07c1);
    meas(3, 16'h003f);
    wr(bce_pkg::A_WS, 16'h0080);
    repeat (210) @(posedge mclk_i);
    for (int i = 0; i < 7; i++)
      rd(RA[i], RV[i]);
    heavy_empty_ratio_i <= 13'h1000;
    meas(0, 16'h0070);
    #1 chk(coulomb_count_o, 16'h0400);
    chk({13'h0000, flg}, 16'h0002);
    @(posedge mclk_i);
    meas(0, 16'h0090);
    meas(3, 16'hff00);
    meas(0, 16'h0070);
    #1 chk(coulomb_count_o, 16'h0300);
    chk({13'h0000, flg}, 16'h0002);
    @(posedge mclk_i);
    meas(0, 16'h0090);
    meas(1, 16'hfe00);
    meas(1, 16'hfe00);
    meas(0, 16'h0070);
    #1 chk(coulomb_count_o, 16'h0400);
    chk({13'h0000, flg}, 16'h0003);
    @(posedge mclk_i);
    meas(3, 16'h0c00);
    meas(2, 16'h0010);
    meas(0, 16'h00d0);
    meas(2, 16'h0010);
    #1 chk(coulomb_count_o, 16'h1000);
    chk({14'h0000, full_charge_flag_o, learn_cycle_flag_o}, 16'h0002);
    @(posedge mclk_i);
    rd(bce_pkg::A_WS, 16'h0080);
    meas(3, 16'hf700);
    repeat (210) @(posedge mclk_i);
    rd(bce_pkg::A_HPCT, 16'h0019);
    #1 chk({13'h0000, flg}, 16'h0000);
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (9) @(posedge mclk_i);
    rd(bce_pkg::A_WS, 16'h007f);
    rd(bce_pkg::A_COND, 16'h00a0);
    // pack maker loads a 95 percent starting scale so a larger capacity can still be learned
    wr(bce_pkg::A_WS, 16'h007a);
    rd(bce_pkg::A_WS, 16'h007a);
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
